// file: verilog/ulwp_params.svh
// offsets, field positions, reset values and counts for the lin and write-protect registers
// Overview of operation
// R1 - node action 00 transmits response, 01 receives it, 10 does neither, 11 reserved
// R2 - lin master: identifier register is read-write and holds the identifier to send
// R3 - lin slave: identifier register is read-only, shows last received identifier
// R4 - read-only sync baud register: divider bits 15..0, fraction bits 18..16
// R5 - protect enable changes only when the written 24-bit key matches the fixed key
// R6 - protect key field always reads back as zero
// R7 - with correct key, writing 1 enables protection, writing 0 disables it
// R8 - protection covers mode, baud, time-out, timeguard, ratio, filter, manchester registers
// R9 - while protection is on, writes to protected registers are ignored
// R10 - violation flag sets on a protected write and stays until status is read
// R11 - violation source field bits 23..8 gives offset of the written register
// R12 - reading protect status returns contents then clears every field
// R13 - read-only revision register: revision in bits 11..0, bits 18..16 reserved
// R14 - all instances have lin, spi, fractional baud; one instance adds the rest
// R15 - every instance offers bus clock divided by eight as baud source
// R16 - receiver time-out counter and its value field are 17 bits wide
// R17 - reserved node action behaves as ignore: no send, no receive
`ifndef ULWP_PARAMS_SVH
`define ULWP_PARAMS_SVH
`define ULWP_OFF_MODE 8'h04
`define ULWP_OFF_IRQ_EN 8'h08
`define ULWP_OFF_IRQ_CLR 8'h0c
`define ULWP_OFF_IRQ_STAT 8'h10
`define ULWP_OFF_BAUD 8'h20
`define ULWP_OFF_RXTO 8'h24
`define ULWP_OFF_TGUARD 8'h28
`define ULWP_OFF_RATIO 8'h40
`define ULWP_OFF_FILTER 8'h4c
`define ULWP_OFF_MANCH 8'h50
`define ULWP_OFF_LINMODE 8'h54
`define ULWP_OFF_LINID 8'h58
`define ULWP_OFF_LINBAUD 8'h5c
`define ULWP_OFF_PMODE 8'he4
`define ULWP_OFF_PSTAT 8'he8
`define ULWP_OFF_REV 8'hfc
`define ULWP_PROTECT_KEY 24'h555341
`define ULWP_MODE_MASTER 4'ha
`define ULWP_MODE_SLAVE 4'hb
`define ULWP_CLKSEL_DIV 2'h1
`define ULWP_DIV_COUNT 3'h7
`define ULWP_TO_W 17
`define ULWP_MAN_RESET 32'h30011004
`define ULWP_IRQ_VIOL 0
`define ULWP_IRQ_IDRX 1
`define ULWP_IRQ_SYNC 2
`define ULWP_IRQ_TO 3
`endif

// file: verilog/ulwp_pkg.sv
// types shared by the lin and write-protect register block
package ulwp_pkg;
	typedef enum logic [1:0] {NA_PUBLISH, NA_SUBSCRIBE, NA_IGNORE, NA_RESERVED} ulwp_node_action_t;
	typedef logic [3:0] ulwp_irq_t;
endpackage

// file: verilog/ulwp_clkdiv.sv
// bus clock divided by eight, as a one-cycle enable
`timescale 1ns/100ps
`include "ulwp_params.svh"
module ulwp_clkdiv
	import ulwp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	output logic div_tick
);
	logic [2:0] count;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= 3'h0;
			div_tick <= 1'b0;
		end
		else if (ce)
		begin
			count <= count + 3'h1; // R15
			div_tick <= (count == `ULWP_DIV_COUNT); // R15
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_DIV_PERIOD: assert property (ce && div_tick && count == 3'h0 |=> !div_tick) // R15
		else $error("divided clock pulse too long");
endmodule

// file: verilog/ulwp_regs.sv
// apb register slice: lin node action and identifier, sync baud, write protection
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "ulwp_params.svh"
module ulwp_regs
	import ulwp_pkg::*;
#(
	parameter bit FULL_FEATURES = 1'b0,
	parameter logic [11:0] REVISION = 12'h0a5 // arbitrary value
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lin_id_rx_valid,
	input wire logic [7:0] lin_id_rx,
	input wire logic sync_done,
	input wire logic [15:0] sync_divider_in,
	input wire logic [2:0] sync_fraction_in,
	input wire logic rx_char_done,
	output logic irq,
	output logic resp_tx_en,
	output logic resp_rx_en,
	output logic lin_master,
	output logic [7:0] lin_tx_id,
	output logic baud_tick,
	output logic rx_timeout
);
	////////////////////////////////////////////////////////////////////////////
	// decoding
	function automatic logic is_protected(input logic [7:0] a);
		is_protected = (a == `ULWP_OFF_MODE) || (a == `ULWP_OFF_BAUD) ||
			(a == `ULWP_OFF_RXTO) || (a == `ULWP_OFF_TGUARD) ||
			(a == `ULWP_OFF_RATIO) || (a == `ULWP_OFF_FILTER) ||
			(a == `ULWP_OFF_MANCH); // R8
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = is_protected(a) || (a == `ULWP_OFF_IRQ_EN) ||
			(a == `ULWP_OFF_IRQ_CLR) || (a == `ULWP_OFF_IRQ_STAT) ||
			(a == `ULWP_OFF_LINMODE) || (a == `ULWP_OFF_LINID) ||
			(a == `ULWP_OFF_LINBAUD) || (a == `ULWP_OFF_PMODE) ||
			(a == `ULWP_OFF_PSTAT) || (a == `ULWP_OFF_REV);
	endfunction

	logic acc;
	logic done;
	logic wr;
	logic rd;
	logic wr_ok;
	logic violation;
	logic div_tick;
	logic src_tick;
	logic to_event;
	logic [31:0] next_rdata;

	logic [31:0] mode_reg;
	logic [31:0] baud_reg;
	logic [`ULWP_TO_W-1:0] rx_timeout_value; // R16
	logic [7:0] tguard_reg;
	logic [10:0] ratio_reg;
	logic [7:0] filter_reg;
	logic [31:0] manch_reg;
	logic [17:0] lin_mode_reg;
	logic [7:0] identifier_char;
	logic [15:0] sync_divider;
	logic [2:0] sync_fraction;
	logic protect_enable;
	logic violation_flag;
	logic [15:0] violation_source;
	ulwp_irq_t irq_status;
	ulwp_irq_t irq_enable;
	ulwp_irq_t irq_event;
	logic [15:0] baud_count;
	logic [`ULWP_TO_W-1:0] to_count;
	ulwp_node_action_t node_action;

	assign acc = psel && penable;
	assign done = acc && pready;
	assign wr = done && pwrite;
	assign rd = done && !pwrite;
	assign violation = wr && protect_enable && is_protected(paddr); // R9
	assign wr_ok = wr && !violation; // R9
	assign node_action = ulwp_node_action_t'(lin_mode_reg[1:0]);

	ulwp_clkdiv u_div (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.div_tick(div_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// apb answer: one wait state, data and error registered with pready
	always_comb
	begin
		next_rdata = 32'h0;
		case (paddr)
			`ULWP_OFF_MODE: next_rdata = mode_reg;
			`ULWP_OFF_IRQ_EN: next_rdata = {28'h0, irq_enable};
			`ULWP_OFF_IRQ_STAT: next_rdata = {28'h0, irq_status};
			`ULWP_OFF_BAUD: next_rdata = baud_reg;
			`ULWP_OFF_RXTO: next_rdata = {15'h0, rx_timeout_value};
			`ULWP_OFF_TGUARD: next_rdata = {24'h0, tguard_reg};
			`ULWP_OFF_RATIO: next_rdata = {21'h0, ratio_reg};
			`ULWP_OFF_FILTER: next_rdata = {24'h0, filter_reg};
			`ULWP_OFF_MANCH: next_rdata = manch_reg;
			`ULWP_OFF_LINMODE: next_rdata = {14'h0, lin_mode_reg};
			`ULWP_OFF_LINID: next_rdata = {24'h0, identifier_char};
			`ULWP_OFF_LINBAUD: next_rdata = {13'h0, sync_fraction, sync_divider}; // R4
			`ULWP_OFF_PMODE: next_rdata = {24'h0, 7'h0, protect_enable}; // R6
			`ULWP_OFF_PSTAT: next_rdata = {8'h0, violation_source, 7'h0, violation_flag};
			`ULWP_OFF_REV: next_rdata = {13'h0, 3'h0, 4'h0, REVISION}; // R13
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			pready <= acc && !pready;
			if (acc && !pready)
			begin
				prdata <= pwrite ? 32'h0 : next_rdata;
				pslverr <= !is_mapped(paddr);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// protected configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_reg <= 32'h0;
			baud_reg <= 32'h0;
			rx_timeout_value <= '0;
			tguard_reg <= 8'h0;
		end
		else if (ce && wr_ok)
		begin
			case (paddr)
				`ULWP_OFF_MODE: mode_reg <= pwdata; // R9
				`ULWP_OFF_BAUD: baud_reg <= pwdata; // R9
				`ULWP_OFF_RXTO: rx_timeout_value <= pwdata[`ULWP_TO_W-1:0]; // R16
				`ULWP_OFF_TGUARD: tguard_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// optional features stay zero when the instance leaves them out
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ratio_reg <= 11'h0;
			filter_reg <= 8'h0;
			manch_reg <= FULL_FEATURES ? `ULWP_MAN_RESET : 32'h0;
		end
		else if (ce && wr_ok && FULL_FEATURES) // R14
		begin
			case (paddr)
				`ULWP_OFF_RATIO: ratio_reg <= pwdata[10:0];
				`ULWP_OFF_FILTER: filter_reg <= pwdata[7:0];
				`ULWP_OFF_MANCH: manch_reg <= pwdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write protection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			protect_enable <= 1'b0;
		else if (ce && wr && paddr == `ULWP_OFF_PMODE && pwdata[31:8] == `ULWP_PROTECT_KEY) // R5
			protect_enable <= pwdata[0]; // R7
	end

	// a new violation wins over the clear-on-read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			violation_flag <= 1'b0;
			violation_source <= 16'h0;
		end
		else if (ce)
		begin
			if (violation)
			begin
				violation_flag <= 1'b1; // R10
				violation_source <= {8'h0, paddr}; // R11
			end
			else if (rd && paddr == `ULWP_OFF_PSTAT)
			begin
				violation_flag <= 1'b0; // R12
				violation_source <= 16'h0; // R12
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lin node
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lin_mode_reg <= 18'h0;
		else if (ce && wr && paddr == `ULWP_OFF_LINMODE)
			lin_mode_reg <= pwdata[17:0];
	end

	// slave capture has priority over a software write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			identifier_char <= 8'h0;
		else if (ce)
		begin
			if (mode_reg[3:0] == `ULWP_MODE_SLAVE && lin_id_rx_valid)
				identifier_char <= lin_id_rx; // R3
			else if (wr && paddr == `ULWP_OFF_LINID && mode_reg[3:0] == `ULWP_MODE_MASTER)
				identifier_char <= pwdata[7:0]; // R2
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_divider <= 16'h0;
			sync_fraction <= 3'h0;
		end
		else if (ce && sync_done)
		begin
			sync_divider <= sync_divider_in; // R4
			sync_fraction <= sync_fraction_in; // R4
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resp_tx_en <= 1'b0;
			resp_rx_en <= 1'b0;
			lin_master <= 1'b0;
			lin_tx_id <= 8'h0;
		end
		else if (ce)
		begin
			case (node_action)
				NA_PUBLISH:
				begin
					resp_tx_en <= 1'b1; // R1
					resp_rx_en <= 1'b0;
				end
				NA_SUBSCRIBE:
				begin
					resp_tx_en <= 1'b0;
					resp_rx_en <= 1'b1; // R1
				end
				default:
				begin
					resp_tx_en <= 1'b0; // R17
					resp_rx_en <= 1'b0; // R17
				end
			endcase
			lin_master <= (mode_reg[3:0] == `ULWP_MODE_MASTER);
			lin_tx_id <= identifier_char; // R2
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// baud source and receiver time-out
	assign src_tick = (mode_reg[5:4] == `ULWP_CLKSEL_DIV) ? div_tick : 1'b1; // R15

	// divider of zero stops the generator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			baud_count <= 16'h0;
			baud_tick <= 1'b0;
		end
		else if (ce)
		begin
			baud_tick <= 1'b0;
			if (src_tick && baud_reg[15:0] != 16'h0)
			begin
				if (baud_count >= baud_reg[15:0] - 16'h1)
				begin
					baud_count <= 16'h0;
					baud_tick <= 1'b1;
				end
				else
					baud_count <= baud_count + 16'h1;
			end
		end
	end

	assign to_event = baud_tick && to_count == `ULWP_TO_W'(1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			to_count <= '0;
			rx_timeout <= 1'b0;
		end
		else if (ce)
		begin
			if (rx_char_done)
				to_count <= rx_timeout_value; // R16
			else if (baud_tick && to_count != '0)
				to_count <= to_count - `ULWP_TO_W'(1);
			if (rx_char_done)
				rx_timeout <= 1'b0;
			else if (to_event)
				rx_timeout <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky status, write-one clear, set wins
	always_comb
	begin
		irq_event = 4'h0;
		irq_event[`ULWP_IRQ_VIOL] = violation;
		irq_event[`ULWP_IRQ_IDRX] = lin_id_rx_valid;
		irq_event[`ULWP_IRQ_SYNC] = sync_done;
		irq_event[`ULWP_IRQ_TO] = to_event;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status <= 4'h0;
			irq_enable <= 4'h0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			if (wr && paddr == `ULWP_OFF_IRQ_CLR)
				irq_status <= (irq_status & ~pwdata[3:0]) | irq_event;
			else
				irq_status <= irq_status | irq_event;
			if (wr && paddr == `ULWP_OFF_IRQ_EN)
				irq_enable <= pwdata[3:0];
			irq <= |(irq_status & irq_enable);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wr(logic [7:0] a);
		ce && psel && penable && pready && pwrite && paddr == a;
	endsequence

	sequence s_rd(logic [7:0] a);
		ce && psel && penable && pready && !pwrite && paddr == a;
	endsequence

	AST_KEY_READS_ZERO: assert property (s_rd(`ULWP_OFF_PMODE) |-> prdata[31:8] == 24'h0) // R6
		else $error("protect key read back nonzero");
	AST_BAD_KEY_HOLDS: assert property
		(s_wr(`ULWP_OFF_PMODE) ##0 pwdata[31:8] != `ULWP_PROTECT_KEY |=> $stable(protect_enable)) // R5
		else $error("protect enable changed with wrong key");
	AST_GOOD_KEY_SETS: assert property
		(s_wr(`ULWP_OFF_PMODE) ##0 pwdata[31:8] == `ULWP_PROTECT_KEY
		|=> protect_enable == $past(pwdata[0])) // R7
		else $error("protect enable not taken with correct key");
	AST_PROTECTED_HOLDS: assert property
		(s_wr(`ULWP_OFF_MODE) ##0 protect_enable |=> $stable(mode_reg)) // R9
		else $error("protected register written");
	AST_VIOLATION_SEEN: assert property
		(ce && violation |=> violation_flag && violation_source == {8'h0, $past(paddr)}) // R11
		else $error("violation not reported");
	AST_STATUS_CLEARS: assert property
		(s_rd(`ULWP_OFF_PSTAT) ##0 !violation
		|=> !violation_flag && violation_source == 16'h0) // R12
		else $error("protect status not cleared by read");
	AST_FLAG_STICKS: assert property
		(ce && violation_flag && !(rd && paddr == `ULWP_OFF_PSTAT) |=> violation_flag) // R10
		else $error("violation flag lost before read");
	AST_NODE_ACTION: assert property
		(ce && node_action == NA_PUBLISH |=> resp_tx_en && !resp_rx_en) // R1
		else $error("publish did not enable transmit");
	AST_RESERVED_IGNORE: assert property
		(ce && node_action == NA_RESERVED |=> !resp_tx_en && !resp_rx_en) // R17
		else $error("reserved action not ignored");
	AST_SLAVE_ID_RO: assert property
		(s_wr(`ULWP_OFF_LINID) ##0 mode_reg[3:0] == `ULWP_MODE_SLAVE && !lin_id_rx_valid
		|=> $stable(identifier_char)) // R3
		else $error("slave identifier written by software");
	AST_REVISION: assert property
		(s_rd(`ULWP_OFF_REV) |-> prdata == {20'h0, REVISION}) // R13
		else $error("revision read wrong");
endmodule

// file: tb/ulwp_lin_node.sv
// model of the other lin nodes: identifier, sync and character events
`timescale 1ns/100ps
module ulwp_lin_node
(
	input wire logic pclk,
	output logic lin_id_rx_valid,
	output logic [7:0] lin_id_rx,
	output logic sync_done,
	output logic [15:0] sync_divider_in,
	output logic [2:0] sync_fraction_in,
	output logic rx_char_done
);
	initial
	begin
		lin_id_rx_valid = 1'b0;
		lin_id_rx = 8'h00;
		sync_done = 1'b0;
		sync_divider_in = 16'h0000;
		sync_fraction_in = 3'h0;
		rx_char_done = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// data lines invert after the pulse so stale values never match
	task automatic send_id(input logic [7:0] id);
		lin_id_rx <= id;
		lin_id_rx_valid <= 1'b1;
		rx_char_done <= 1'b1;
		@(posedge pclk);
		lin_id_rx_valid <= 1'b0;
		rx_char_done <= 1'b0;
		lin_id_rx <= ~id;
	endtask
	task automatic sync_meas(input logic [15:0] dv, input logic [2:0] fr);
		sync_divider_in <= dv;
		sync_fraction_in <= fr;
		sync_done <= 1'b1;
		@(posedge pclk);
		sync_done <= 1'b0;
		sync_divider_in <= ~dv;
		sync_fraction_in <= ~fr;
	endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the lin and write-protect register slice
`timescale 1ns/100ps
`include "ulwp_params.svh"
module tb;
	import ulwp_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, resp_tx_en, resp_rx_en, lin_master, baud_tick, rx_timeout;
	logic [7:0] lin_tx_id, lin_id_rx;
	logic lin_id_rx_valid, sync_done, rx_char_done;
	logic [15:0] sync_divider_in;
	logic [2:0] sync_fraction_in;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [31:0] rnd;
	logic [7:0] offs [0:6] = '{`ULWP_OFF_MODE, `ULWP_OFF_BAUD, `ULWP_OFF_RXTO,
		`ULWP_OFF_TGUARD, `ULWP_OFF_RATIO, `ULWP_OFF_FILTER, `ULWP_OFF_MANCH};
	integer n_errors = 0;
	integer n_checks = 0;
	integer seed = 32588;
	integer cnt = 0;
	always #10 pclk = ~pclk;
	ulwp_regs dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lin_id_rx_valid(lin_id_rx_valid), .lin_id_rx(lin_id_rx), .sync_done(sync_done),
		.sync_divider_in(sync_divider_in), .sync_fraction_in(sync_fraction_in),
		.rx_char_done(rx_char_done), .irq(irq), .resp_tx_en(resp_tx_en),
		.resp_rx_en(resp_rx_en), .lin_master(lin_master), .lin_tx_id(lin_tx_id),
		.baud_tick(baud_tick), .rx_timeout(rx_timeout));
	ulwp_lin_node lin_u (.pclk(pclk), .lin_id_rx_valid(lin_id_rx_valid),
		.lin_id_rx(lin_id_rx), .sync_done(sync_done), .sync_divider_in(sync_divider_in),
		.sync_fraction_in(sync_fraction_in), .rx_char_done(rx_char_done));
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] x);
		n_checks++;
		if (seen !== x)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, x, seen);
		end
	endtask
	// request held until pready is sampled high; one idle cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] x, input logic err);
		exp_q.push_back({~w, err, x});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, x, 1'b0);
	endtask
	task automatic settle;
		repeat (3) @(posedge pclk);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// answer seen at the completion edge, oldest note first
	always @(posedge pclk)
		if (pready === 1'b1)
		begin
			e = exp_q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
			if (e[33])
				check("prdata", prdata, e[31:0]);
		end
	initial
	begin
		#100000;
		n_errors++;
		final_report();
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`ULWP_OFF_LINID, 32'h0);
		rd(`ULWP_OFF_LINBAUD, 32'h0);
		rd(`ULWP_OFF_PMODE, 32'h0);
		rd(`ULWP_OFF_PSTAT, 32'h0);
		rd(`ULWP_OFF_REV, 32'h000000a5);
		apb(1'b0, 8'h80, 32'h0, 32'h0, 1'b1);
		wr(`ULWP_OFF_MODE, {28'h0, `ULWP_MODE_MASTER});
		rnd = $random(seed);
		wr(`ULWP_OFF_LINID, rnd);
		rd(`ULWP_OFF_LINID, {24'h0, rnd[7:0]});
		settle();
		check("lin_master", {31'h0, lin_master}, 32'h1);
		check("lin_tx_id", {24'h0, lin_tx_id}, {24'h0, rnd[7:0]});
		for (int k = 0; k < 4; k++)
		begin
			wr(`ULWP_OFF_LINMODE, 32'(k));
			settle();
			check("resp_tx_en", {31'h0, resp_tx_en}, {31'h0, k == 0});
			check("resp_rx_en", {31'h0, resp_rx_en}, {31'h0, k == 1});
		end
		wr(`ULWP_OFF_RXTO, 32'hffffffff);
		rd(`ULWP_OFF_RXTO, 32'h0001ffff);
		wr(`ULWP_OFF_PMODE, {24'h123456, 8'h01});
		rd(`ULWP_OFF_PMODE, 32'h0);
		wr(`ULWP_OFF_PMODE, {`ULWP_PROTECT_KEY, 8'h01});
		rd(`ULWP_OFF_PMODE, 32'h1);
		foreach (offs[i])
		begin
			wr(offs[i], 32'h0000000b);
			rd(`ULWP_OFF_MODE, 32'h0000000a);
			rd(`ULWP_OFF_PSTAT, {16'h0, offs[i], 8'h01});
			rd(`ULWP_OFF_PSTAT, 32'h0);
		end
		// sticky status outlives the enable: mask, then clear
		wr(`ULWP_OFF_IRQ_EN, 32'h1);
		settle();
		check("irq", {31'h0, irq}, 32'h1);
		wr(`ULWP_OFF_IRQ_EN, 32'h0);
		settle();
		check("irq", {31'h0, irq}, 32'h0);
		rd(`ULWP_OFF_IRQ_STAT, 32'h1);
		wr(`ULWP_OFF_IRQ_CLR, 32'h1);
		rd(`ULWP_OFF_IRQ_STAT, 32'h0);
		wr(`ULWP_OFF_PMODE, {`ULWP_PROTECT_KEY, 8'h00});
		rd(`ULWP_OFF_PMODE, 32'h0);
		wr(`ULWP_OFF_FILTER, 32'h000000ff);
		rd(`ULWP_OFF_FILTER, 32'h0);
		wr(`ULWP_OFF_MODE, 32'h0000001b);
		rd(`ULWP_OFF_MODE, 32'h0000001b);
		rd(`ULWP_OFF_PSTAT, 32'h0);
		rnd = $random(seed);
		lin_u.send_id(rnd[7:0]);
		rd(`ULWP_OFF_LINID, {24'h0, rnd[7:0]});
		wr(`ULWP_OFF_LINID, ~rnd);
		rd(`ULWP_OFF_LINID, {24'h0, rnd[7:0]});
		rnd = $random(seed);
		lin_u.sync_meas(rnd[15:0], rnd[18:16]);
		rd(`ULWP_OFF_LINBAUD, {13'h0, rnd[18:0]});
		// divider of one on the clk/8 source: one tick every 8 cycles
		wr(`ULWP_OFF_BAUD, 32'h1);
		settle();
		repeat (80)
		begin
			@(posedge pclk);
			cnt += (baud_tick === 1'b1);
		end
		check("baud_tick count", cnt, 32'd10);
		// two baud ticks after a character the time-out fires
		wr(`ULWP_OFF_RXTO, 32'h2);
		lin_u.send_id(8'h3c);
		repeat (30) @(posedge pclk);
		check("rx_timeout", {31'h0, rx_timeout}, 32'h1);
		rd(`ULWP_OFF_IRQ_STAT, 32'h0000000e);
		// frozen clock enable: character event and identifier are both missed
		ce <= 1'b0;
		lin_u.send_id(8'hc3);
		ce <= 1'b1;
		settle();
		check("rx_timeout frozen", {31'h0, rx_timeout}, 32'h1);
		rd(`ULWP_OFF_LINID, 32'h0000003c);
		lin_u.send_id(8'h5a);
		settle();
		check("rx_timeout cleared", {31'h0, rx_timeout}, 32'h0);
		rd(`ULWP_OFF_LINID, 32'h0000005a);
		final_report();
	end
endmodule
